//--- src/vis_defines.svh
// Numeric constants of the video input select and fallback block.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef VIS_DEFINES_SVH
`define VIS_DEFINES_SVH

// Clocks
`define VIS_CLK_MHZ 50
`define VIS_REF_MHZ 27
`define VIS_DAC_BITS 10
`define VIS_DAC_CLK_KHZ 148500

// Serial clock lock window
`define VIS_LOCK_WIN_NS 1000
`define VIS_LOCK_CYC ((`VIS_LOCK_WIN_NS * `VIS_CLK_MHZ) / 1000)

// Timing reference watchdog
`define VIS_TRS_WIN_US 100
`define VIS_TRS_WIN_CYC (`VIS_TRS_WIN_US * `VIS_CLK_MHZ)

// Timing reference words and flag positions
`define VIS_TRS_PRE 10'h3ff
`define VIS_TRS_ZERO 10'h000
`define VIS_XYZ_H 6
`define VIS_XYZ_V 7

// Lines per frame
`define VIS_LINES_720 750
`define VIS_LINES_1080 1125

// Frame period in reference ticks, and tolerance
`define VIS_T_720P25 1080000
`define VIS_T_720P30 900000
`define VIS_T_720P50 540000
`define VIS_T_720P5994 450450
`define VIS_T_720P60 450000
`define VIS_T_1080P24 1125000
`define VIS_T_1080P25 1080000
`define VIS_T_1080P2997 900900
`define VIS_T_1080P30 900000
`define VIS_TICK_TOL 200

// Colour bars: samples per bar, 75% luma levels
`define VIS_BAR_W_720 8'd160
`define VIS_BAR_W_1080 8'd240
`define VIS_BAR_Y0 10'h2d1
`define VIS_BAR_Y1 10'h2a2
`define VIS_BAR_Y2 10'h245
`define VIS_BAR_Y3 10'h216
`define VIS_BAR_Y4 10'h0fb
`define VIS_BAR_Y5 10'h0cc
`define VIS_BAR_Y6 10'h06f
`define VIS_BAR_Y7 10'h040

// Protection checksum stream
`define VIS_PROT_LEN 8
`define VIS_LFSR_SEED 8'h01

`endif

//--- src/vis_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two and one clock for both sides.
`timescale 1ns/100ps
module vis_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } vis_fifo_s;

  vis_fifo_s s_q, s_d;
  logic push, pop;

  assign o_in_ready = (s_q.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (s_q.cnt != '0);
  assign o_out_data = s_q.mem[s_q.rd];

  always_comb begin
    s_d = s_q;
    push = i_in_valid && o_in_ready;
    pop = i_out_ready && o_out_valid;
    if (push) begin
      s_d.mem[s_q.wr] = i_in_data;
      s_d.wr = s_q.wr + AW'(1);
    end
    if (pop) begin
      s_d.rd = s_q.rd + AW'(1);
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : vis_fifo

//--- src/vis_pkg.sv
// Types shared by the video input select and fallback block.
// Assumes the numeric figures live in vis_defines.svh.
package vis_pkg;

  typedef enum logic [1:0] {
    MODE_BARS,
    MODE_SDI,
    MODE_DVI
  } vis_mode_e;

  typedef enum logic [3:0] {
    STD_NONE,
    STD_720P25,
    STD_720P30,
    STD_720P50,
    STD_720P5994,
    STD_720P60,
    STD_1080P24,
    STD_1080P25,
    STD_1080P2997,
    STD_1080P30
  } vis_std_e;

  // Pin group passed through the synchroniser
  typedef struct packed {
    logic sdi_clk;
    logic [9:0] sdi_word;
    logic dvi_clk;
    logic dvi_valid;
    logic dvi_de;
    logic [9:0] dvi_word;
    logic [3:0] dvi_std;
    logic prot_valid;
    logic [7:0] prot_sum;
  } vis_pins_s;

  typedef struct packed {
    vis_pins_s s1;
    vis_pins_s s2;
    logic sdi_prev;
    logic dvi_prev;
    logic [7:0] lock_cnt;
    logic [2:0][9:0] hist;
    logic [15:0] trs_cnt;
    logic v_prev;
    logic [11:0] line_cnt;
    logic [23:0] tick_cnt;
    logic [5:0] ref_acc;
    vis_std_e sdi_std;
    vis_std_e last_std;
    logic seen_any;
    vis_mode_e mode;
    logic [7:0] bar_pos;
    logic [2:0] bar_idx;
    logic [9:0] samp;
    logic samp_v;
    logic [7:0] lfsr;
    logic [7:0] psum;
    logic [7:0] pword;
    logic [2:0] pn;
    logic pstb;
    logic pend;
    logic pwait;
    logic pvalid_prev;
    logic shutdown;
  } vis_state_s;

endpackage : vis_pkg

//--- src/vis_top.sv
// Input selection and colour bar fallback for a video transmitter.
// Assumes slow link clocks sampled by i_clk, and a DAC-side stage that
// retimes the sample stream into the 148.5 MHz converter domain.
// Function
// [RL1] With serial and DVI both present, serial video wins.
// [RL2] The serial lock lamp lights while serial clock edges keep arriving.
// [RL3] Serial video is used only with live timing references and a supported standard.
// [RL4] Valid DVI with no serial input lights the hot-plug lamp and is encoded.
// [RL5] On input loss, 75% bars are made at the last detected standard.
// [RL6] With no input ever detected, bars run at 720p 60 Hz.
// [RL7] A fractional last standard makes the bars run at 720p 60 Hz.
// [RL8] Serial standard is measured against a fixed 27 MHz timebase.
// [RL9] A returned checksum that differs from ours shuts the module down.
// [RL10] Output goes to the converter as 10-bit samples, one per converter cycle.
// [RL11] The DVI receiver supplies 4:2:2 video on a fixed pixel clock.
// [RL12] Serial lanes arrive deserialised; we extract timing references and format.
// [RL13] When live input returns, bars stop and the same priority applies.
`timescale 1ns/100ps
`include "vis_defines.svh"
module vis_top #(
  parameter int P_TRS_WIN = `VIS_TRS_WIN_CYC,
  parameter int P_TICK_SHIFT = 0,
  parameter int P_LINES_720 = `VIS_LINES_720,
  parameter int P_LINES_1080 = `VIS_LINES_1080
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Serial deserialiser
  input wire logic i_sdi_link_clk,
  input wire logic [9:0] i_sdi_word,
  // DVI receiver
  input wire logic i_dvi_pix_clk,
  input wire logic i_dvi_valid,
  input wire logic i_dvi_de,
  input wire logic [9:0] i_dvi_word,
  input wire logic [3:0] i_dvi_std,
  // Protection chip
  output logic [7:0] o_prot_word,
  output logic o_prot_stb,
  output logic o_prot_end,
  input wire logic i_prot_valid,
  input wire logic [7:0] i_prot_sum,
  // Converter stream
  output logic [`VIS_DAC_BITS-1:0] o_dac_data,
  output logic o_dac_valid,
  input wire logic i_dac_ready,
  // Indicators and status
  output logic o_serial_input_locked_lamp,
  output logic o_hot_plug_lamp,
  output logic o_shutdown,
  output vis_pkg::vis_mode_e o_mode,
  output vis_pkg::vis_std_e o_bar_std
);
  vis_pkg::vis_state_s s_q, s_d;
  vis_pkg::vis_pins_s pins;
  vis_pkg::vis_std_e dvi_std, bar_std;
  logic sdi_edge, dvi_edge, trs_hit, frame_mark, ref_tick, sdi_ok, dvi_ok, prot_rise;
  logic last_frac;
  logic fifo_in_ready, fifo_out_valid;
  logic [9:0] fifo_out_data;
  logic [7:0] bar_w;

  assign pins = '{sdi_clk: i_sdi_link_clk, sdi_word: i_sdi_word, dvi_clk: i_dvi_pix_clk,
                  dvi_valid: i_dvi_valid, dvi_de: i_dvi_de, dvi_word: i_dvi_word,
                  dvi_std: i_dvi_std, prot_valid: i_prot_valid, prot_sum: i_prot_sum};

  function automatic logic near(input logic [31:0] t, input logic [31:0] nom);
    near = (t + 32'(`VIS_TICK_TOL) >= nom) && (t <= nom + 32'(`VIS_TICK_TOL));
  endfunction : near

  // [RL8] Frame period in 27 MHz ticks and line count
  function automatic vis_pkg::vis_std_e classify(input logic [11:0] lines, input logic [23:0] ticks);
    logic [31:0] t;
    t = 32'(ticks) << P_TICK_SHIFT;
    classify = vis_pkg::STD_NONE;
    if (lines == 12'(P_LINES_720)) begin
      if (near(t, 32'(`VIS_T_720P25))) classify = vis_pkg::STD_720P25;
      if (near(t, 32'(`VIS_T_720P30))) classify = vis_pkg::STD_720P30;
      if (near(t, 32'(`VIS_T_720P50))) classify = vis_pkg::STD_720P50;
      if (near(t, 32'(`VIS_T_720P5994))) classify = vis_pkg::STD_720P5994;
      if (near(t, 32'(`VIS_T_720P60))) classify = vis_pkg::STD_720P60;
    end else if (lines == 12'(P_LINES_1080)) begin
      if (near(t, 32'(`VIS_T_1080P24))) classify = vis_pkg::STD_1080P24;
      if (near(t, 32'(`VIS_T_1080P25))) classify = vis_pkg::STD_1080P25;
      if (near(t, 32'(`VIS_T_1080P2997))) classify = vis_pkg::STD_1080P2997;
      if (near(t, 32'(`VIS_T_1080P30))) classify = vis_pkg::STD_1080P30;
    end
  endfunction : classify

  function automatic logic [9:0] bar_luma(input logic [2:0] idx);
    case (idx)
      3'h0: bar_luma = `VIS_BAR_Y0;
      3'h1: bar_luma = `VIS_BAR_Y1;
      3'h2: bar_luma = `VIS_BAR_Y2;
      3'h3: bar_luma = `VIS_BAR_Y3;
      3'h4: bar_luma = `VIS_BAR_Y4;
      3'h5: bar_luma = `VIS_BAR_Y5;
      3'h6: bar_luma = `VIS_BAR_Y6;
      default: bar_luma = `VIS_BAR_Y7;
    endcase
  endfunction : bar_luma

  always_comb begin
    s_d = s_q;
    s_d.s1 = pins;
    s_d.s2 = s_q.s1;
    s_d.sdi_prev = s_q.s2.sdi_clk;
    s_d.dvi_prev = s_q.s2.dvi_clk;
    sdi_edge = s_q.s2.sdi_clk && !s_q.sdi_prev;
    dvi_edge = s_q.s2.dvi_clk && !s_q.dvi_prev;
    trs_hit = 1'b0;
    frame_mark = 1'b0;
    // [RL2] Lamp held while edges keep coming
    if (sdi_edge) begin
      s_d.lock_cnt = 8'(`VIS_LOCK_CYC);
    end else if (s_q.lock_cnt != 8'h00) begin
      s_d.lock_cnt = s_q.lock_cnt - 8'h01;
    end
    // [RL8] Fractional divider gives 27 ticks per 50 clocks
    ref_tick = (7'(s_q.ref_acc) + 7'(`VIS_REF_MHZ)) >= 7'(`VIS_CLK_MHZ);
    s_d.ref_acc = ref_tick ? 6'(7'(s_q.ref_acc) + 7'(`VIS_REF_MHZ) - 7'(`VIS_CLK_MHZ))
                           : 6'(7'(s_q.ref_acc) + 7'(`VIS_REF_MHZ));
    if (ref_tick) begin
      s_d.tick_cnt = s_q.tick_cnt + 24'h000001;
    end
    // [RL12] Preamble 3ff 000 000 then the flag word
    if (sdi_edge) begin
      s_d.hist = {s_q.hist[1:0], s_q.s2.sdi_word};
      trs_hit = (s_q.hist[2] == `VIS_TRS_PRE) && (s_q.hist[1] == `VIS_TRS_ZERO) &&
                (s_q.hist[0] == `VIS_TRS_ZERO);
    end
    if (trs_hit) begin
      s_d.trs_cnt = 16'(P_TRS_WIN);
      if (s_q.s2.sdi_word[`VIS_XYZ_H]) begin
        s_d.line_cnt = s_q.line_cnt + 12'h001;
        s_d.v_prev = s_q.s2.sdi_word[`VIS_XYZ_V];
        frame_mark = s_q.s2.sdi_word[`VIS_XYZ_V] && !s_q.v_prev;
      end
    end else if (s_q.trs_cnt != 16'h0000) begin
      s_d.trs_cnt = s_q.trs_cnt - 16'h0001;
    end
    if (frame_mark) begin
      s_d.sdi_std = classify(s_q.line_cnt + 12'h001, s_q.tick_cnt);
      s_d.line_cnt = 12'h000;
      s_d.tick_cnt = 24'h000000;
    end
    // [RL3] Lock, live references and a known standard
    sdi_ok = (s_q.lock_cnt != 8'h00) && (s_q.trs_cnt != 16'h0000) && (s_q.sdi_std != vis_pkg::STD_NONE);
    dvi_std = (s_q.s2.dvi_std > 4'(vis_pkg::STD_1080P30)) ? vis_pkg::STD_NONE
                                                         : vis_pkg::vis_std_e'(s_q.s2.dvi_std);
    // [RL4] DVI only when the serial input is absent
    dvi_ok = s_q.s2.dvi_valid && (s_q.lock_cnt == 8'h00);
    // [RL1] [RL5] [RL13] Priority re-evaluated every cycle
    if (sdi_ok) begin
      s_d.mode = vis_pkg::MODE_SDI;
    end else if (dvi_ok) begin
      s_d.mode = vis_pkg::MODE_DVI;
    end else begin
      s_d.mode = vis_pkg::MODE_BARS;
    end
    // [RL5] Remember what the live source carried
    // Serial may reclassify as none while still selected; keep the last real one
    if (s_q.mode == vis_pkg::MODE_SDI && s_q.sdi_std != vis_pkg::STD_NONE) begin
      s_d.last_std = s_q.sdi_std;
      s_d.seen_any = 1'b1;
    end else if (s_q.mode == vis_pkg::MODE_DVI && dvi_std != vis_pkg::STD_NONE) begin
      s_d.last_std = dvi_std;
      s_d.seen_any = 1'b1;
    end
    last_frac = (s_q.last_std == vis_pkg::STD_720P5994) || (s_q.last_std == vis_pkg::STD_1080P2997);
    // [RL6] [RL7] Fallback standard
    bar_std = (s_q.seen_any && !last_frac && s_q.last_std != vis_pkg::STD_NONE) ? s_q.last_std
                                                                              : vis_pkg::STD_720P60;
    bar_w = (bar_std >= vis_pkg::STD_1080P24) ? `VIS_BAR_W_1080 : `VIS_BAR_W_720;
    // Sample path; live words are dropped if the FIFO is full
    if (s_q.samp_v && fifo_in_ready) begin
      s_d.samp_v = 1'b0;
    end
    case (s_q.mode)
      vis_pkg::MODE_SDI: begin
        if (sdi_edge) begin
          s_d.samp = s_q.s2.sdi_word;
          s_d.samp_v = 1'b1;
        end
      end
      vis_pkg::MODE_DVI: begin
        if (dvi_edge && s_q.s2.dvi_de) begin
          s_d.samp = s_q.s2.dvi_word;
          s_d.samp_v = 1'b1;
        end
      end
      vis_pkg::MODE_BARS: begin
        // [RL5] Bars stall on back-pressure
        if (!s_q.samp_v || fifo_in_ready) begin
          s_d.samp = bar_luma(s_q.bar_idx);
          s_d.samp_v = 1'b1;
          if (s_q.bar_pos >= bar_w - 8'h01) begin
            s_d.bar_pos = 8'h00;
            s_d.bar_idx = s_q.bar_idx + 3'h1;
          end else begin
            s_d.bar_pos = s_q.bar_pos + 8'h01;
          end
        end
      end
      default: begin
        s_d.samp_v = 1'b0;
      end
    endcase
    // [RL9] Stream to the protection chip and compare its answer
    s_d.pstb = 1'b0;
    s_d.pend = 1'b0;
    s_d.pvalid_prev = s_q.s2.prot_valid;
    prot_rise = s_q.s2.prot_valid && !s_q.pvalid_prev;
    if (!s_q.pwait) begin
      s_d.pword = s_q.lfsr;
      s_d.pstb = 1'b1;
      s_d.psum = s_q.psum + s_q.lfsr;
      s_d.lfsr = {s_q.lfsr[6:0], s_q.lfsr[7] ^ s_q.lfsr[5] ^ s_q.lfsr[4] ^ s_q.lfsr[3]};
      s_d.pn = s_q.pn + 3'h1;
      if (s_q.pn == 3'(`VIS_PROT_LEN - 1)) begin
        s_d.pend = 1'b1;
        s_d.pwait = 1'b1;
      end
    end else if (prot_rise) begin
      if (s_q.s2.prot_sum != s_q.psum) begin
        s_d.shutdown = 1'b1;
      end
      s_d.psum = 8'h00;
      s_d.pwait = 1'b0;
    end
    if (s_q.shutdown) begin
      s_d.samp_v = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
      s_q.lfsr <= `VIS_LFSR_SEED;
    end else begin
      s_q <= s_d;
    end
  end

  // [RL10] Elastic stage ahead of the converter
  vis_fifo #(.WIDTH(`VIS_DAC_BITS), .DEPTH(4)) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(s_q.samp_v && !s_q.shutdown),
    .o_in_ready(fifo_in_ready),
    .i_in_data(s_q.samp),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(i_dac_ready),
    .o_out_data(fifo_out_data)
  );

  // Shutdown mutes the converter even with words left inside
  assign o_dac_valid = fifo_out_valid && !s_q.shutdown;
  assign o_dac_data = s_q.shutdown ? 10'h000 : fifo_out_data;
  assign o_serial_input_locked_lamp = (s_q.lock_cnt != 8'h00);
  assign o_hot_plug_lamp = (s_q.mode == vis_pkg::MODE_DVI);
  assign o_shutdown = s_q.shutdown;
  assign o_mode = s_q.mode;
  assign o_bar_std = bar_std;
  assign o_prot_word = s_q.pword;
  assign o_prot_stb = s_q.pstb;
  assign o_prot_end = s_q.pend;

  // Helper: ticks over a 50-clock window
  logic [5:0] win_q, wticks_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      win_q <= 6'h00;
      wticks_q <= 6'h00;
    end else if (win_q == 6'(`VIS_CLK_MHZ - 1)) begin
      win_q <= 6'h00;
      wticks_q <= 6'h00;
    end else begin
      win_q <= win_q + 6'h01;
      wticks_q <= wticks_q + 6'(ref_tick);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_mismatch;
    s_q.pwait && prot_rise && (s_q.s2.prot_sum != s_q.psum);
  endsequence
  sequence s_muted;
    o_shutdown && !o_dac_valid ##1 o_shutdown;
  endsequence

  chk_sdi_priority: assert property (sdi_ok && s_q.s2.dvi_valid |=> o_mode == vis_pkg::MODE_SDI) // [RL1]
    else $error("serial input not preferred");
  chk_lock_lamp_hold: assert property (sdi_edge ##1 (!sdi_edge) [*8] |-> o_serial_input_locked_lamp) // [RL2]
    else $error("lock lamp dropped while clock live");
  chk_sdi_qualified: assert property (o_mode == vis_pkg::MODE_SDI |-> $past(sdi_ok)) // [RL3]
    else $error("serial used without valid timing");
  chk_dvi_hot_plug: assert property (dvi_ok && !sdi_ok |=> o_hot_plug_lamp && o_mode == vis_pkg::MODE_DVI) // [RL4]
    else $error("DVI not selected");
  chk_bars_on_loss: assert property (!sdi_ok && !dvi_ok |=> o_mode == vis_pkg::MODE_BARS) // [RL5]
    else $error("no fallback to bars");
  chk_bars_last_std: assert property (s_q.seen_any && !last_frac |-> o_bar_std == s_q.last_std) // [RL5]
    else $error("bars not at last standard");
  chk_bars_default: assert property (!s_q.seen_any |-> o_bar_std == vis_pkg::STD_720P60) // [RL6]
    else $error("bars default wrong");
  chk_bars_fraction: assert property (last_frac |-> o_bar_std == vis_pkg::STD_720P60) // [RL7]
    else $error("fractional standard not replaced");
  chk_ref_tick_rate: assert property (win_q == 6'(`VIS_CLK_MHZ - 1) |-> wticks_q + 6'(ref_tick) == 6'd27) // [RL8]
    else $error("reference timebase off rate");
  chk_prot_shutdown: assert property (s_mismatch |=> s_muted) // [RL9]
    else $error("checksum mismatch did not shut down");
  chk_dac_hold_stall: assert property (o_dac_valid && !i_dac_ready && !o_shutdown
                                       |=> $stable(o_dac_data) || o_shutdown) // [RL10]
    else $error("converter sample changed under stall");
  chk_trs_line_count: assert property (trs_hit && s_q.s2.sdi_word[`VIS_XYZ_H] && !frame_mark
                                       |=> s_q.line_cnt == $past(s_q.line_cnt) + 12'h001) // [RL12]
    else $error("line not counted at reference");
  chk_live_return: assert property (o_mode == vis_pkg::MODE_BARS && sdi_ok |=> o_mode == vis_pkg::MODE_SDI) // [RL13]
    else $error("live serial input not resumed");
endmodule : vis_top

//--- verif/tb.sv
// Bench for vis_top: bars, FIFO stall through the top, DVI, serial, protection.
// Assumes vis_src_model as far side and shortened frame parameters.
`timescale 1ns/100ps
`include "vis_defines.svh"
module tb;
  localparam logic [9:0] BAR_Y [8] = '{`VIS_BAR_Y0, `VIS_BAR_Y1, `VIS_BAR_Y2, `VIS_BAR_Y3,
    `VIS_BAR_Y4, `VIS_BAR_Y5, `VIS_BAR_Y6, `VIS_BAR_Y7};
  logic i_clk, i_rst_n, sdi_en, dvi_en, corrupt, rdy;
  logic sclk, dclk, pstb, pend, pvalid, dvalid, slamp, hlamp, shut;
  logic [9:0] sword, dword, ddata;
  logic [3:0] dstd;
  logic [7:0] pword, psum;
  vis_pkg::vis_mode_e mode;
  vis_pkg::vis_std_e bstd;
  int err_count, total_checks;

  initial i_clk = 1'b0;
  always #10 i_clk = ~i_clk;

  vis_src_model src (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sdi_en(sdi_en), .i_dvi_en(dvi_en),
    .i_corrupt(corrupt), .o_sdi_clk(sclk), .o_sdi_word(sword), .o_dvi_clk(dclk), .o_dvi_word(dword),
    .i_pword(pword), .i_pstb(pstb), .i_pend(pend), .o_pvalid(pvalid), .o_psum(psum));

  // Short frames: 6 or 9 lines, tick count scaled by 64
  vis_top #(.P_TRS_WIN(4000), .P_TICK_SHIFT(6), .P_LINES_720(6), .P_LINES_1080(9)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sdi_link_clk(sclk), .i_sdi_word(sword),
    .i_dvi_pix_clk(dclk), .i_dvi_valid(dvi_en), .i_dvi_de(dvi_en), .i_dvi_word(dword),
    .i_dvi_std(dvi_en ? dstd : 4'hf), .o_prot_word(pword), .o_prot_stb(pstb), .o_prot_end(pend),
    .i_prot_valid(pvalid), .i_prot_sum(psum), .o_dac_data(ddata), .o_dac_valid(dvalid),
    .i_dac_ready(rdy), .o_serial_input_locked_lamp(slamp), .o_hot_plug_lamp(hlamp),
    .o_shutdown(shut), .o_mode(mode), .o_bar_std(bstd));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task automatic give_up;
    err_count++;
    $display("Error at %0t: wait ran out", $time);
    close_out();
  endtask : give_up

  task automatic wait_mode(input vis_pkg::vis_mode_e m, input int lim);
    for (int n = 0; mode !== m; n++) begin
      if (n > lim) give_up();
      @(negedge i_clk);
    end
  endtask : wait_mode

  task automatic take_sample(output logic [9:0] d);
    for (int n = 0; dvalid !== 1'b1; n++) begin
      if (n > 20) give_up();
      @(negedge i_clk);
    end
    d = ddata;
    @(negedge i_clk);
  endtask : take_sample

  // One full line of bars, with a stall part way through the first bar
  task automatic t_bars;
    logic [9:0] d;
    rdy = 1'b1;
    for (int k = 0; k < 1280; k++) begin
      if (k == 50) begin
        rdy = 1'b0;
        d = ddata;
        repeat (10) @(negedge i_clk);
        check(dvalid, 1'b1);
        check(ddata, d);
        rdy = 1'b1;
      end
      take_sample(d);
      check(d, BAR_Y[k / 160]);
    end
  endtask : t_bars

  // Ready still high: fill the FIFO while stalled, drain back to back across a bar edge
  task automatic t_fifo;
    logic [9:0] d;
    for (int k = 0; k < 150; k++) take_sample(d);
    rdy = 1'b0;
    repeat (10) @(negedge i_clk);
    check(dvalid, 1'b1);
    check(ddata, BAR_Y[0]);
    rdy = 1'b1;
    for (int k = 150; k < 170; k++) begin
      check(dvalid, 1'b1);
      check(ddata, BAR_Y[k / 160]);
      @(negedge i_clk);
    end
    rdy = 1'b0;
  endtask : t_fifo

  // Every standard on DVI, then the fallback it leaves behind
  task automatic t_dvi;
    logic [9:0] d, d2;
    for (int s = 1; s < 10; s++) begin
      dstd = 4'(s);
      dvi_en = 1'b1;
      wait_mode(vis_pkg::MODE_DVI, 100);
      check(hlamp, 1'b1);
      if (s == 1) begin
        // Flush old bar words, then two live words must be a chroma/luma pair
        d = 10'h000;
        rdy = 1'b1;
        for (int n = 0; n < 12 && d != 10'h200 && d != 10'h1a0; n++) take_sample(d);
        take_sample(d2);
        rdy = 1'b0;
        check(d ^ d2, 10'h3a0);
      end
      repeat (4) @(negedge i_clk);
      dvi_en = 1'b0;
      wait_mode(vis_pkg::MODE_BARS, 100);
      check(hlamp, 1'b0);
      if (dstd == vis_pkg::STD_720P5994 || dstd == vis_pkg::STD_1080P2997) begin
        check(bstd, vis_pkg::STD_720P60);
      end else begin
        check(bstd, 16'(s));
      end
    end
  endtask : t_dvi

  // Serial wins over DVI once classified, bars follow its loss
  task automatic t_sdi;
    sdi_en = 1'b1;
    for (int n = 0; slamp !== 1'b1; n++) begin
      if (n > 100) give_up();
      @(negedge i_clk);
    end
    check(mode, vis_pkg::MODE_BARS);
    dstd = vis_pkg::STD_1080P30;
    dvi_en = 1'b1;
    repeat (10) @(negedge i_clk);
    check(mode, vis_pkg::MODE_BARS);
    check(hlamp, 1'b0);
    wait_mode(vis_pkg::MODE_SDI, 60000);
    check(slamp, 1'b1);
    check(hlamp, 1'b0);
    dvi_en = 1'b0;
    repeat (20) @(negedge i_clk);
    check(mode, vis_pkg::MODE_SDI);
    sdi_en = 1'b0;
    wait_mode(vis_pkg::MODE_BARS, 6000);
    check(slamp, 1'b0);
    check(bstd, vis_pkg::STD_720P50);
  endtask : t_sdi

  task automatic t_prot;
    rdy = 1'b1;
    repeat (200) @(negedge i_clk);
    check(shut, 1'b0);
    check(dvalid, 1'b1);
    corrupt = 1'b1;
    for (int n = 0; shut !== 1'b1; n++) begin
      if (n > 100) give_up();
      @(negedge i_clk);
    end
    repeat (2) @(negedge i_clk);
    check(dvalid, 1'b0);
    check(ddata, 10'h000);
  endtask : t_prot

  initial begin
    i_rst_n = 1'b0;
    sdi_en = 1'b0;
    dvi_en = 1'b0;
    dstd = 4'h0;
    corrupt = 1'b0;
    rdy = 1'b0;
    err_count = 0;
    total_checks = 0;
    repeat (3) @(negedge i_clk);
    check(mode, vis_pkg::MODE_BARS);
    check(bstd, vis_pkg::STD_720P60);
    check(dvalid, 1'b0);
    repeat (3) @(negedge i_clk);
    i_rst_n = 1'b1;
    t_bars();
    t_fifo();
    t_dvi();
    t_sdi();
    t_prot();
    close_out();
  end
endmodule : tb

//--- verif/vis_src_model.sv
// Far-side model: serial deserialiser, DVI receiver and protection chip.
// Assumes the bench enables each source; link pins are async to i_clk, protection pins change on its falling edge.
`timescale 1ns/100ps
module vis_src_model (
  // Control
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sdi_en,
  input wire logic i_dvi_en,
  input wire logic i_corrupt,
  // Serial
  output logic o_sdi_clk,
  output logic [9:0] o_sdi_word,
  // DVI
  output logic o_dvi_clk,
  output logic [9:0] o_dvi_word,
  // Protection
  input wire logic [7:0] i_pword,
  input wire logic i_pstb,
  input wire logic i_pend,
  output logic o_pvalid,
  output logic [7:0] o_psum
);
  // One 720p50 frame scaled down: 6 lines, 1953 words of 160 ns
  localparam int FRAME_W = 1953;
  localparam int LINE_W = 326;
  logic [7:0] acc;
  logic [7:0] blk;
  event blk_ev;

  initial begin
    o_sdi_clk = 1'b0;
    o_sdi_word = 10'h155;
    #7;
    forever begin
      wait (i_sdi_en);
      for (int w = 0; w < FRAME_W && i_sdi_en; w++) begin
        // Timing ref at line start, V set on first line
        case (w % LINE_W)
          0: o_sdi_word = 10'h3ff;
          1, 2: o_sdi_word = 10'h000;
          3: o_sdi_word = (w < LINE_W) ? 10'h0c0 : 10'h040;
          default: o_sdi_word = 10'h200;
        endcase
        #80 o_sdi_clk = 1'b1;
        #80 o_sdi_clk = 1'b0;
      end
      // Released line must not keep showing the last word
      if (!i_sdi_en) o_sdi_word = ~o_sdi_word;
    end
  end

  initial begin
    o_dvi_clk = 1'b0;
    o_dvi_word = 10'h155;
    #13;
    forever begin
      #80;
      // 4:2:2 chroma/luma pairs on a steady pixel clock
      if (i_dvi_en) begin
        o_dvi_clk = ~o_dvi_clk;
        if (!o_dvi_clk) o_dvi_word = (o_dvi_word == 10'h200) ? 10'h1a0 : 10'h200;
      end else begin
        o_dvi_clk = 1'b0;
        o_dvi_word = ~o_dvi_word;
      end
    end
  end

  always @(negedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) acc = 8'h00;
    else if (i_pstb === 1'b1) begin
      acc = acc + i_pword;
      if (i_pend === 1'b1) begin
        blk = acc;
        acc = 8'h00;
        -> blk_ev;
      end
    end
  end

  initial begin
    o_pvalid = 1'b0;
    o_psum = 8'h5a;
    forever begin
      @(blk_ev);
      // Chip returns the byte sum, damaged only on request
      repeat (2) @(negedge i_clk);
      o_psum = i_corrupt ? (blk ^ 8'h01) : blk;
      repeat (2) @(negedge i_clk);
      o_pvalid = 1'b1;
      repeat (6) @(negedge i_clk);
      o_pvalid = 1'b0;
      o_psum = ~o_psum;
    end
  end
endmodule : vis_src_model
